/* rtl/tif_pkg.sv */
package tif_pkg;

   localparam int ID_W            = 29;
   localparam int STD_LSB         = 18;
   localparam int REG_W           = 16;
   localparam int AW              = 8;

   // Register indices; byte address is four times the index
   localparam logic [AW-1:0] IDX_REF_LOW   = 8'h28;
   localparam logic [AW-1:0] IDX_REF_HIGH  = 8'h2A;
   localparam logic [AW-1:0] IDX_MASK_LOW  = 8'h2C;
   localparam logic [AW-1:0] IDX_MASK_HIGH = 8'h2E;
   localparam logic [AW-1:0] IDX_MODE      = 8'h30;
   localparam logic [AW-1:0] IDX_STATUS    = 8'h32;

   localparam logic [9:0] ADDR_REF_LOW   = {IDX_REF_LOW, 2'b00};
   localparam logic [9:0] ADDR_REF_HIGH  = {IDX_REF_HIGH, 2'b00};
   localparam logic [9:0] ADDR_MASK_LOW  = {IDX_MASK_LOW, 2'b00};
   localparam logic [9:0] ADDR_MASK_HIGH = {IDX_MASK_HIGH, 2'b00};
   localparam logic [9:0] ADDR_MODE      = {IDX_MODE, 2'b00};
   localparam logic [9:0] ADDR_STATUS    = {IDX_STATUS, 2'b00};

   // Fields of the upper reference register
   localparam int HI_IDE_BIT      = 15;
   localparam int HI_LINK_BIT     = 14;
   localparam int HI_ZERO_BIT     = 13;
   localparam int HI_ID_MSB       = 12;

   // Mode register
   localparam int MODE_INIT_BIT   = 0;
   localparam logic MODE_INIT_RST = 1'b1;

   // Status register fields
   localparam int ST_LAST_BIT     = 16;
   localparam int ST_CNT_W        = 16;

   localparam logic [REG_W-1:0] REG_RST  = 16'h0000;
   localparam logic [31:0]      DATA_ZERO = 32'h0000_0000;

   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [1:0] HTRANS_SEQ    = 2'b11;
   localparam logic       HRESP_OKAY    = 1'b0;

endpackage : tif_pkg

/* rtl/tif_transfer_id_filter.sv */
// How it works
// - Standard frames compare reference bits 28 to 18
// - Extended frames compare all 29 reference bits
// - Format bit: 0 standard, 1 extended
// - Standard format ignores reference bits 17 to 0
// - Mask link bit 1 applies mask, 0 not
// - Reference writes dropped outside initialization mode
// - Mask writes dropped outside initialization mode
// - Mask bit 0: received bit must match
// - Mask bit 1: received bit is don't-care
// - Masking widens frames accepted to upper buffers
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module tif_transfer_id_filter
   import tif_pkg::*;
(
   input  wire logic              CLK,
   input  wire logic              SYS_RST,
   input  wire logic              CE,
   input  wire logic              HSEL,
   input  wire logic [31:0]       HADDR,
   input  wire logic [1:0]        HTRANS,
   input  wire logic              HWRITE,
   input  wire logic [2:0]        HSIZE,
   input  wire logic [31:0]       HWDATA,
   input  wire logic              HREADY,
   output logic                   HREADYOUT,
   output logic                   HRESP,
   output logic [31:0]            HRDATA,
   input  wire logic              RX_VALID,
   input  wire logic [ID_W-1:0]   RX_ID,
   input  wire logic              RX_IDE,
   output logic                   RX_DONE,
   output logic                   RX_ACCEPT,
   output logic                   INIT_MODE
);

   // Stored register images
   logic [REG_W-1:0]    ref_low;
   logic [REG_W-1:0]    ref_high;
   logic [REG_W-1:0]    mask_low;
   logic [REG_W-1:0]    mask_high;
   logic                init_mode;
   logic                last_accept;
   logic [ST_CNT_W-1:0] accept_count;

   // Values that a bus write would load
   logic [REG_W-1:0]    next_ref_low;
   logic [REG_W-1:0]    next_ref_high;
   logic [REG_W-1:0]    next_mask_low;
   logic [REG_W-1:0]    next_mask_high;
   logic                next_init;

   // Bus side
   logic                trans_active;
   logic                access;
   logic                addr_in_map;
   logic                wr_pend;
   logic [9:0]          wr_addr;
   logic                wr_ref_ok;
   logic                wr_mask_ok;
   logic                wr_ref_low;
   logic                wr_ref_high;
   logic                wr_mask_low;
   logic                wr_mask_high;
   logic                wr_mode;

   // Read words, each register zero-extended to the bus width
   logic [31:0]         rd_ref_low;
   logic [31:0]         rd_ref_high;
   logic [31:0]         rd_mask_low;
   logic [31:0]         rd_mask_high;
   logic [31:0]         rd_mode;
   logic [31:0]         rd_status;
   logic [31:0]         next_rdata;

   // Filter datapath
   logic [ID_W-1:0]     ref_id;
   logic [ID_W-1:0]     mask_id;
   logic                ide_sel;
   logic                link_en;
   logic [ID_W-1:0]     bit_eq;
   logic [ID_W-1:0]     bit_masked;
   logic [ID_W-1:0]     bit_unused;
   logic [ID_W-1:0]     bit_ok;
   logic                rx_take;
   logic                format_ok;
   logic                id_ok;
   logic                next_accept;
   logic [ST_CNT_W-1:0] next_count;

   // HSIZE is not decoded: only whole-word transfers are supported
   assign trans_active = (HTRANS == HTRANS_NONSEQ) | (HTRANS == HTRANS_SEQ);
   assign access       = HSEL & HREADY & trans_active;

   // Aliases above the decoded range would otherwise hit real registers
   assign addr_in_map  = (HADDR[31:10] == '0);

   // Write strobes, qualified by the data-phase address
   assign wr_ref_ok    = wr_pend & init_mode;
   assign wr_mask_ok   = wr_pend & init_mode;
   assign wr_ref_low   = wr_ref_ok & (wr_addr == ADDR_REF_LOW);
   assign wr_ref_high  = wr_ref_ok & (wr_addr == ADDR_REF_HIGH);
   assign wr_mask_low  = wr_mask_ok & (wr_addr == ADDR_MASK_LOW);
   assign wr_mask_high = wr_mask_ok & (wr_addr == ADDR_MASK_HIGH);

   // Mode stays writable in every mode, else software could never return to init
   assign wr_mode      = wr_pend & (wr_addr == ADDR_MODE);

   // Unused upper bits read as zero
   assign rd_ref_low   = {16'h0000, ref_low};
   assign rd_ref_high  = {16'h0000, ref_high};
   assign rd_mask_low  = {16'h0000, mask_low};
   assign rd_mask_high = {16'h0000, mask_high};
   assign rd_mode      = {31'h0000_0000, init_mode};
   assign rd_status    = {15'h0000, last_accept, accept_count};

   assign next_ref_low   = HWDATA[REG_W-1:0];
   // Bit 13 of the upper reference always stores zero, whatever is written
   assign next_ref_high  = {HWDATA[HI_IDE_BIT:HI_LINK_BIT], 1'b0,
                            HWDATA[HI_ID_MSB:0]};
   assign next_mask_low  = HWDATA[REG_W-1:0];
   // Mask bits above the top identifier bit do not exist
   assign next_mask_high = {3'b000, HWDATA[HI_ID_MSB:0]};
   assign next_init      = HWDATA[MODE_INIT_BIT];

   assign ref_id  = {ref_high[HI_ID_MSB:0], ref_low};
   assign mask_id = {mask_high[HI_ID_MSB:0], mask_low};
   assign ide_sel = ref_high[HI_IDE_BIT];
   assign link_en = ref_high[HI_LINK_BIT];

   // One compare slice per identifier bit; a bit passes when equal,
   // masked through the link, or outside the standard range
   for (genvar i = 0; i < ID_W; i++) begin : g_cmp
      assign bit_eq[i]     = (RX_ID[i] == ref_id[i]);
      assign bit_masked[i] = link_en & mask_id[i];
      assign bit_unused[i] = ~ide_sel & (i < STD_LSB);
      assign bit_ok[i]     = bit_eq[i] | bit_masked[i] | bit_unused[i];
   end

   assign rx_take     = CE & RX_VALID;
   assign format_ok   = (RX_IDE == ide_sel);
   assign id_ok       = &bit_ok;
   assign next_accept = format_ok & id_ok;

   // Counter wraps at full scale; software works with differences
   assign next_count  = accept_count + 16'h0001;

   // Write address phase is remembered; its data lands one cycle later
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         wr_pend <= 1'b0;
      end else if (CE) begin
         wr_pend <= access & HWRITE & addr_in_map;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         wr_addr <= '0;
      end else if (CE) begin
         if (access) begin
            wr_addr <= HADDR[9:0];
         end
      end
   end

   // Zero wait states and an OKAY reply, so no error path is needed
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         HREADYOUT <= 1'b1;
      end else if (CE) begin
         HREADYOUT <= 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         HRESP <= HRESP_OKAY;
      end else if (CE) begin
         HRESP <= HRESP_OKAY;
      end
   end

   always_comb begin
      next_rdata = DATA_ZERO;
      case (HADDR[9:0])
         ADDR_REF_LOW: begin
            next_rdata = rd_ref_low;
         end
         ADDR_REF_HIGH: begin
            next_rdata = rd_ref_high;
         end
         ADDR_MASK_LOW: begin
            next_rdata = rd_mask_low;
         end
         ADDR_MASK_HIGH: begin
            next_rdata = rd_mask_high;
         end
         ADDR_MODE: begin
            next_rdata = rd_mode;
         end
         ADDR_STATUS: begin
            next_rdata = rd_status;
         end
         default: begin
            next_rdata = DATA_ZERO;
         end
      endcase
      if (!addr_in_map) begin
         next_rdata = DATA_ZERO;
      end
   end

   // Read data holds between reads, so a slow master still finds it
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         HRDATA <= DATA_ZERO;
      end else if (CE) begin
         if (access && !HWRITE) begin
            HRDATA <= next_rdata;
         end
      end
   end

   // Filter settings only move in init, so a frame outside init never sees half a setting
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ref_low <= REG_RST;
      end else if (CE) begin
         if (wr_ref_low) begin
            ref_low <= next_ref_low;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         ref_high <= REG_RST;
      end else if (CE) begin
         if (wr_ref_high) begin
            ref_high <= next_ref_high;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         mask_low <= REG_RST;
      end else if (CE) begin
         if (wr_mask_low) begin
            mask_low <= next_mask_low;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         mask_high <= REG_RST;
      end else if (CE) begin
         if (wr_mask_high) begin
            mask_high <= next_mask_high;
         end
      end
   end

   // The internal mode bit and its output copy are kept apart,
   // so the port stays a plain flip-flop
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         init_mode <= MODE_INIT_RST;
      end else if (CE) begin
         if (wr_mode) begin
            init_mode <= next_init;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         INIT_MODE <= MODE_INIT_RST;
      end else if (CE) begin
         if (wr_mode) begin
            INIT_MODE <= next_init;
         end
      end
   end

   // Frames are filtered in every mode; the result is a one-cycle pulse
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         RX_DONE <= 1'b0;
      end else if (CE) begin
         RX_DONE <= RX_VALID;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         RX_ACCEPT <= 1'b0;
      end else if (CE) begin
         RX_ACCEPT <= RX_VALID & next_accept;
      end
   end

   // Last result and count give software a view without the pulse outputs
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         last_accept <= 1'b0;
      end else if (CE) begin
         if (rx_take) begin
            last_accept <= next_accept;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         accept_count <= '0;
      end else if (CE) begin
         if (rx_take && next_accept) begin
            accept_count <= next_count;
         end
      end
   end

endmodule : tif_transfer_id_filter

`default_nettype wire

/* test/tif_can_node.sv */
`timescale 1ns/1ps
`default_nettype none
module tif_can_node
   import tif_pkg::*;
(
   input  wire logic     clk,
   output logic          rx_valid,
   output logic [ID_W-1:0] rx_id,
   output logic          rx_ide
);
   initial begin
      rx_valid = 1'b0;
      rx_id = '0;
      rx_ide = 1'b0;
   end
   task automatic send(input logic [ID_W-1:0] id, input logic ide);
      rx_valid <= 1'b1;
      rx_id <= id;
      rx_ide <= ide;
      @(posedge clk);
      rx_valid <= 1'b0;
      // Stale lines flip so a late sample cannot pass by luck
      rx_id <= ~id;
      rx_ide <= ~ide;
   endtask : send
   // Two frames on consecutive cycles, valid held high between them
   task automatic send2(input logic [ID_W-1:0] id_a, input logic ide_a,
                        input logic [ID_W-1:0] id_b, input logic ide_b);
      rx_valid <= 1'b1;
      rx_id <= id_a;
      rx_ide <= ide_a;
      @(posedge clk);
      rx_id <= id_b;
      rx_ide <= ide_b;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_id <= ~id_b;
      rx_ide <= ~ide_b;
   endtask : send2
endmodule : tif_can_node
`default_nettype wire

/* test/tif_filter_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module tif_filter_chk (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic [31:0] HRDATA,
   input wire logic RX_VALID,
   input wire logic RX_DONE,
   input wire logic RX_ACCEPT
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   property p_rdy; HREADYOUT && !HRESP; endproperty
   a_rdy: assert property (p_rdy) else $error("wait or error reply");
   property p_done; RX_VALID && CE |=> RX_DONE; endproperty
   a_done: assert property (p_done) else $error("no result pulse");
   property p_idle; !RX_VALID && CE |=> !RX_DONE; endproperty
   a_idle: assert property (p_idle) else $error("spurious result");
   property p_acc; RX_ACCEPT |-> RX_DONE; endproperty
   a_acc: assert property (p_acc) else $error("accept without result");
   property p_two; RX_VALID && CE ##1 RX_VALID && CE |-> RX_DONE ##1 RX_DONE; endproperty
   a_two: assert property (p_two) else $error("back to back lost");
   property p_frz; !CE |=> $stable({RX_DONE, RX_ACCEPT, HRDATA}); endproperty
   a_frz: assert property (p_frz) else $error("moved while frozen");
   property p_hrs; !(CE && HSEL && HREADY && HTRANS[1] && !HWRITE) |=> $stable(HRDATA);
   endproperty
   a_hrs: assert property (p_hrs) else $error("read data moved");
   property p_up; HRDATA[31:17] == 15'h0; endproperty
   a_up: assert property (p_up) else $error("upper read bits set");
   c_acc: cover property (RX_ACCEPT);
   c_rej: cover property (RX_DONE && !RX_ACCEPT);
   c_ce: cover property (!CE && RX_VALID);
endmodule : tif_filter_chk
bind tif_transfer_id_filter tif_filter_chk chk_u (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE),
   .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
   .HRESP(HRESP), .HRDATA(HRDATA), .RX_VALID(RX_VALID), .RX_DONE(RX_DONE),
   .RX_ACCEPT(RX_ACCEPT));
`default_nettype wire

/* test/test_can_transfer_id_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module test_can_transfer_id_filter
   import tif_pkg::*;
;
   localparam logic [ID_W-1:0] R = 29'h0ACE_1234;
   logic clk, rst, ce, hsel, hwr, rdy, hresp, done, acc, init, rval, ride;
   logic [1:0] htr;
   logic [31:0] haddr, hwd, hrd, q;
   logic [ID_W-1:0] rid;
   int error_cnt = 0;
   int cmp_count = 0;
   tif_transfer_id_filter dut_u (.CLK(clk), .SYS_RST(rst), .CE(ce), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htr), .HWRITE(hwr), .HSIZE(3'h2), .HWDATA(hwd), .HREADY(rdy),
      .HREADYOUT(rdy), .HRESP(hresp), .HRDATA(hrd), .RX_VALID(rval), .RX_ID(rid),
      .RX_IDE(ride), .RX_DONE(done), .RX_ACCEPT(acc), .INIT_MODE(init));
   tif_can_node node_u (.clk(clk), .rx_valid(rval), .rx_id(rid), .rx_ide(ride));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic ck(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask : ck
   task automatic bus(input logic [9:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {22'h0, a};
      htr <= HTRANS_NONSEQ;
      hwr <= w;
      do @(posedge clk); while (rdy !== 1'b1);
      hsel <= 1'b0;
      htr <= 2'h0;
      hwd <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      q = hrd;
   endtask : bus
   task automatic setref(input logic ide, input logic lk);
      bus(ADDR_REF_LOW, 1'b1, {16'h0, R[15:0]});
      bus(ADDR_REF_HIGH, 1'b1, {16'h0, ide, lk, 1'b0, R[28:16]});
   endtask : setref
   task automatic fr(input logic [ID_W-1:0] id, input logic ide, input logic e);
      node_u.send(id, ide);
      @(negedge clk);
      ck({30'h0, done, acc}, {30'h0, 1'b1, e});
      @(posedge clk);
   endtask : fr
   task automatic t_std;
      bus(ADDR_MODE, 1'b0, DATA_ZERO);
      ck(q, 32'h1);
      setref(1'b0, 1'b0);
      fr(R ^ 29'h0003_FFFF, 1'b0, 1'b1);
      fr(R ^ 29'h0004_0000, 1'b0, 1'b0);
      fr(R, 1'b1, 1'b0);
   endtask : t_std
   task automatic t_ext;
      setref(1'b1, 1'b0);
      fr(R, 1'b1, 1'b1);
      fr(R ^ 29'h1, 1'b1, 1'b0);
      fr(R, 1'b0, 1'b0);
   endtask : t_ext
   task automatic t_mask;
      bus(ADDR_MASK_LOW, 1'b1, 32'h1);
      setref(1'b1, 1'b1);
      fr(R ^ 29'h1, 1'b1, 1'b1);
      fr(R ^ 29'h2, 1'b1, 1'b0);
      setref(1'b1, 1'b0);
      fr(R ^ 29'h1, 1'b1, 1'b0);
   endtask : t_mask
   task automatic t_lock;
      bus(ADDR_MODE, 1'b1, DATA_ZERO);
      setref(1'b0, 1'b1);
      bus(ADDR_MASK_LOW, 1'b1, DATA_ZERO);
      bus(ADDR_REF_HIGH, 1'b0, DATA_ZERO);
      ck(q, {16'h0, 3'h4, R[28:16]});
      bus(ADDR_MASK_LOW, 1'b0, DATA_ZERO);
      ck(q, 32'h1);
      bus(10'h3FC, 1'b0, DATA_ZERO);
      ck(q, DATA_ZERO);
      ck({31'h0, init}, 32'h0);
      fr(R ^ 29'h1, 1'b1, 1'b0);
      ce <= 1'b0;
      node_u.send(R, 1'b1);
      @(negedge clk);
      ck({31'h0, done}, 32'h0);
      @(posedge clk);
      ce <= 1'b1;
   endtask : t_lock
   task automatic t_b2b;
      node_u.send2(R, 1'b1, R ^ 29'h0000_0001, 1'b1);
      @(negedge clk);
      ck({30'h0, done, acc}, {30'h0, 1'b1, 1'b0});
      @(posedge clk);
      bus(ADDR_STATUS, 1'b0, DATA_ZERO);
      ck(q, 32'h0000_0004);
   endtask : t_b2b
   task automatic end_of_test;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      hsel = 1'b0;
      htr = 2'h0;
      hwr = 1'b0;
      haddr = '0;
      hwd = '0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_std;
      t_ext;
      t_mask;
      t_lock;
      t_b2b;
      end_of_test;
   end
   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      end_of_test;
   end
endmodule : test_can_transfer_id_filter
`default_nettype wire
